// file: rdpm_defines.svh
`ifndef RDPM_DEFINES_SVH
`define RDPM_DEFINES_SVH

// register byte offsets
`define RDPM_CTRL_OFS 8'h00
`define RDPM_STATUS_OFS 8'h04
`define RDPM_CFG0_OFS 8'h08
`define RDPM_CFG1_OFS 8'h0c
`define RDPM_DETPER_OFS 8'h10

// control fields
`define RDPM_CTRL_FORCE_LP 0
`define RDPM_CTRL_RESET 32'h0000_0000

// detection period: 100 us at 50 ns clock
`define RDPM_DET_PERIOD_US 100
`define RDPM_CLK_NS 50
`define RDPM_DET_PERIOD_CYC ((`RDPM_DET_PERIOD_US * 1000) / `RDPM_CLK_NS)

// idle timeout before low power: 10 us
`define RDPM_IDLE_US 10
`define RDPM_IDLE_CYC ((`RDPM_IDLE_US * 1000) / `RDPM_CLK_NS)

// strap level encoding
`define RDPM_LVL_LOW 2'h0
`define RDPM_LVL_FLOAT 2'h1
`define RDPM_LVL_HIGH 2'h2

// settings codes
`define RDPM_GAIN_3DB 2'h0
`define RDPM_GAIN_6DB 2'h1
`define RDPM_GAIN_9DB 2'h2
`define RDPM_SWING_0P9 1'b0
`define RDPM_SWING_1P1 1'b1
`define RDPM_DE_0DB 2'h0
`define RDPM_DE_3P5DB 2'h1
`define RDPM_DE_6P2DB 2'h2

`endif

// file: rdpm_pkg.sv
package rdpm_pkg;

	// power mode states
	typedef enum logic [2:0] {
		PM_SHUTDOWN,
		PM_DISCONNECT,
		PM_U0,
		PM_LOWPOWER
	} rdpm_state_type;

	// per channel decoded settings
	typedef struct packed {
		logic [1:0] gain;
		logic swing;
		logic [1:0] deemph;
	} rdpm_chan_type;

endpackage

// file: rdpm_strap_if.sv
`timescale 1ns/100ps

// decoded settings from the strap decoder to the control core
interface rdpm_strap_if;
	logic [1:0] gain [2];
	logic swing [2];
	logic [1:0] deemph [2];

	modport decoder (output gain, output swing, output deemph);
	modport core (input gain, input swing, input deemph);
endinterface

// file: rdpm_strap_decode.sv
`timescale 1ns/100ps
`include "rdpm_defines.svh"

module rdpm_strap_decode
	import rdpm_pkg::*;
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// synchronised strap levels per channel
	input wire logic [1:0] gain_lvl [2],
	input wire logic swing_lvl [2],
	input wire logic [1:0] deemph_lvl [2],
	// decoded settings
	rdpm_strap_if.decoder dec
);

	typedef struct packed {
		rdpm_chan_type [1:0] ch;
	} rdpm_dec_state_type;

	rdpm_dec_state_type s_q;
	rdpm_dec_state_type s_d;

	// three level to gain code; an unknown level falls back to the middle
	function automatic logic [1:0] dec_gain(input logic [1:0] lvl);
		unique case (lvl)
			`RDPM_LVL_LOW: dec_gain = `RDPM_GAIN_3DB;
			`RDPM_LVL_HIGH: dec_gain = `RDPM_GAIN_9DB;
			default: dec_gain = `RDPM_GAIN_6DB;
		endcase
	endfunction

	// three level to de-emphasis code, same for either swing
	function automatic logic [1:0] dec_de(input logic [1:0] lvl);
		unique case (lvl)
			`RDPM_LVL_LOW: dec_de = `RDPM_DE_0DB;
			`RDPM_LVL_HIGH: dec_de = `RDPM_DE_6P2DB;
			default: dec_de = `RDPM_DE_3P5DB;
		endcase
	endfunction

	// each channel decoded only from its own inputs
	always_comb begin
		s_d = s_q;
		for (int i = 0; i < 2; i++) begin
			s_d.ch[i].gain = dec_gain(gain_lvl[i]);
			s_d.ch[i].swing = swing_lvl[i] ? `RDPM_SWING_1P1 : `RDPM_SWING_0P9;
			s_d.ch[i].deemph = dec_de(deemph_lvl[i]);
		end
	end

	// register the settings
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// drive the interface
	generate
		for (genvar g = 0; g < 2; g++) begin : g_out
			assign dec.gain[g] = s_q.ch[g].gain;
			assign dec.swing[g] = s_q.ch[g].swing;
			assign dec.deemph[g] = s_q.ch[g].deemph;
		end
	endgenerate

endmodule

// file: rdpm_core.sv
// The AHB-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`include "rdpm_defines.svh"

module rdpm_core
	import rdpm_pkg::*;
#(
	parameter logic [31:0] DET_PERIOD_CYC = `RDPM_DET_PERIOD_CYC,
	parameter logic [31:0] IDLE_CYC = `RDPM_IDLE_CYC
)
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// pins from outside, synchronised here
	input wire logic enable_pin,
	input wire logic [1:0] rx_gain_select [2],
	input wire logic tx_swing_select [2],
	input wire logic [1:0] tx_deemph_select [2],
	// analog front end status
	input wire logic [1:0] far_term_seen,
	input wire logic [1:0] rx_activity,
	input wire logic [1:0] lfps_seen,
	// analog front end control
	output logic [1:0] rx_detect_start,
	output logic [1:0] rx_term_en,
	output logic redrive_en,
	output logic low_power,
	output logic shutdown,
	output logic [1:0] eq_gain [2],
	output logic tx_swing [2],
	output logic [1:0] tx_deemph [2]
);

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		logic [1:0] en_sync;
		logic [1:0][1:0] gain_s1;
		logic [1:0][1:0] gain_s2;
		logic [1:0] swing_s1;
		logic [1:0] swing_s2;
		logic [1:0][1:0] de_s1;
		logic [1:0][1:0] de_s2;
		logic [1:0] term_s1;
		logic [1:0] term_s2;
		logic [1:0] act_s1;
		logic [1:0] act_s2;
		logic [1:0] lfps_s1;
		logic [1:0] lfps_s2;
		rdpm_state_type pm;
		logic [31:0] det_cnt;
		logic [31:0] idle_cnt;
		logic force_lp;
		logic data_ph;
		logic wr_ph;
		logic [7:0] addr_ph;
		logic [31:0] rdata;
		logic [1:0] det_start;
		logic [1:0] term_en;
		logic redrive;
		logic lp;
		logic sd;
		logic [1:0][1:0] gain_o;
		logic [1:0] swing_o;
		logic [1:0][1:0] de_o;
		logic [31:0] det_per;
	} rdpm_core_state_type;

	rdpm_core_state_type s_q;
	rdpm_core_state_type s_d;

	rdpm_strap_if straps();
	logic [1:0] gain_lvl [2];
	logic swing_lvl [2];
	logic [1:0] de_lvl [2];

	// synchronised straps feed the decoder
	generate
		for (genvar g = 0; g < 2; g++) begin : g_lvl
			assign gain_lvl[g] = s_q.gain_s2[g];
			assign swing_lvl[g] = s_q.swing_s2[g];
			assign de_lvl[g] = s_q.de_s2[g];
		end
	endgenerate

	rdpm_strap_decode u_dec (
		.hclk(hclk),
		.hresetn(hresetn),
		.gain_lvl(gain_lvl),
		.swing_lvl(swing_lvl),
		.deemph_lvl(de_lvl),
		.dec(straps.decoder)
	);

	// read mux over the register map; unmapped reads return zero
	function automatic logic [31:0] rd_mux(input logic [7:0] a, input rdpm_core_state_type st);
		logic [31:0] v;
		v = 32'h0000_0000;
		unique case (a)
			`RDPM_CTRL_OFS: v = {31'h0, st.force_lp};
			`RDPM_STATUS_OFS: v = {22'h0, st.lfps_s2, st.act_s2, st.term_s2, st.sd, st.lp, st.redrive,
				st.pm == PM_U0};
			`RDPM_CFG0_OFS: v = {27'h0, st.gain_o[0], st.swing_o[0], st.de_o[0]};
			`RDPM_CFG1_OFS: v = {27'h0, st.gain_o[1], st.swing_o[1], st.de_o[1]};
			`RDPM_DETPER_OFS: v = st.det_per;
			default: v = 32'h0000_0000;
		endcase
		return v;
	endfunction

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		logic det_tick;
		logic busy;
		det_tick = 1'b0;
		busy = 1'b0;
		s_d = s_q;

		// two-flop synchronisers for every pin and analog status
		s_d.en_sync = {s_q.en_sync[0], enable_pin};
		for (int i = 0; i < 2; i++) begin
			s_d.gain_s1[i] = rx_gain_select[i];
			s_d.swing_s1[i] = tx_swing_select[i];
			s_d.de_s1[i] = tx_deemph_select[i];
		end
		s_d.gain_s2 = s_q.gain_s1;
		s_d.swing_s2 = s_q.swing_s1;
		s_d.de_s2 = s_q.de_s1;
		s_d.term_s1 = far_term_seen;
		s_d.term_s2 = s_q.term_s1;
		s_d.act_s1 = rx_activity;
		s_d.act_s2 = s_q.act_s1;
		s_d.lfps_s1 = lfps_seen;
		s_d.lfps_s2 = s_q.lfps_s1;

		// ahb-lite: zero wait states, always okay
		if (s_q.data_ph && s_q.wr_ph) begin
			if (s_q.addr_ph == `RDPM_CTRL_OFS) begin
				s_d.force_lp = hwdata[`RDPM_CTRL_FORCE_LP];
			end
			if (s_q.addr_ph == `RDPM_DETPER_OFS) begin
				s_d.det_per = (hwdata == 32'h0) ? 32'h1 : hwdata;
			end
		end
		s_d.data_ph = hsel && hready && htrans[1];
		s_d.wr_ph = hwrite;
		s_d.addr_ph = {haddr[7:2], 2'b00};
		if (hsel && hready && htrans[1] && !hwrite) begin
			s_d.rdata = rd_mux({haddr[7:2], 2'b00}, s_q);
		end

		// periodic detection timer
		if (s_q.det_cnt >= s_q.det_per - 32'h1) begin
			s_d.det_cnt = 32'h0;
			det_tick = 1'b1;
		end else begin
			s_d.det_cnt = s_q.det_cnt + 32'h1;
		end
		s_d.det_start = 2'b00;
		busy = |s_q.act_s2 || |s_q.lfps_s2;

		// power mode machine
		if (!s_q.en_sync[1]) begin
			s_d.pm = PM_SHUTDOWN;
		end else begin
			unique case (s_q.pm)
				PM_SHUTDOWN: begin
					s_d.pm = PM_DISCONNECT;
					s_d.det_cnt = 32'h0;
				end
				PM_DISCONNECT: begin
					if (det_tick) begin
						s_d.det_start = 2'b11;
					end
					if (&s_q.term_s2) begin
						s_d.pm = PM_U0;
						s_d.idle_cnt = 32'h0;
					end
				end
				PM_U0: begin
					// a lost partner ends U0 even mid-traffic, so redrive never runs on half termination
					if (!(&s_q.term_s2)) begin
						s_d.pm = PM_DISCONNECT;
					end else if (busy) begin
						s_d.idle_cnt = 32'h0;
					end else if (s_q.force_lp || s_q.idle_cnt >= IDLE_CYC - 32'h1) begin
						s_d.pm = PM_LOWPOWER;
					end else begin
						s_d.idle_cnt = s_q.idle_cnt + 32'h1;
					end
				end
				PM_LOWPOWER: begin
					if (det_tick) begin
						s_d.det_start = 2'b11;
					end
					if (!(&s_q.term_s2)) begin
						s_d.pm = PM_DISCONNECT;
					end else if (busy && !s_q.force_lp) begin
						s_d.pm = PM_U0;
						s_d.idle_cnt = 32'h0;
					end
				end
				default: s_d.pm = PM_SHUTDOWN;
			endcase
		end

		// termination follows a detected receiver
		s_d.term_en = (s_d.pm == PM_U0 || s_d.pm == PM_LOWPOWER) ? s_q.term_s2 : 2'b00;
		s_d.redrive = (s_d.pm == PM_U0);
		s_d.lp = (s_d.pm == PM_LOWPOWER);
		s_d.sd = (s_d.pm == PM_SHUTDOWN);

		// settings out; lfps on a channel's input forces its de-emphasis off
		for (int i = 0; i < 2; i++) begin
			s_d.gain_o[i] = straps.gain[i];
			s_d.swing_o[i] = straps.swing[i];
			s_d.de_o[i] = s_q.lfps_s2[i] ? `RDPM_DE_0DB : straps.deemph[i];
		end
	end

	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q <= '0;
			s_q.pm <= PM_SHUTDOWN;
			s_q.sd <= 1'b1;
			s_q.det_per <= DET_PERIOD_CYC;
		end else begin
			s_q <= s_d;
		end
	end

	// outputs straight from flops; hreadyout and hresp tied off
	assign hrdata = s_q.rdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign rx_detect_start = s_q.det_start;
	assign rx_term_en = s_q.term_en;
	assign redrive_en = s_q.redrive;
	assign low_power = s_q.lp;
	assign shutdown = s_q.sd;
	generate
		for (genvar g = 0; g < 2; g++) begin : g_set
			assign eq_gain[g] = s_q.gain_o[g];
			assign tx_swing[g] = s_q.swing_o[g];
			assign tx_deemph[g] = s_q.de_o[g];
		end
	endgenerate

endmodule

// file: rdpm_props.sv
`timescale 1ns/100ps
// ****************
// power mode checker
// ****************
module rdpm_props #(
	parameter logic [31:0] DET_PERIOD_CYC = 32'h7d0
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// pins and front end status
	input wire logic enable_pin,
	input wire logic [1:0] rx_gain_select [2],
	input wire logic [1:0] far_term_seen,
	input wire logic [1:0] rx_activity,
	input wire logic [1:0] lfps_seen,
	// front end control
	input wire logic [1:0] rx_detect_start,
	input wire logic [1:0] rx_term_en,
	input wire logic redrive_en,
	input wire logic low_power,
	input wire logic shutdown,
	input wire logic [1:0] eq_gain [2],
	input wire logic [1:0] tx_deemph [2]
);
	logic [31:0] gap_q;
	logic [31:0] gap_d;
	// cycles since the last probe, shutdown or redrive cycle; a written shorter period only tightens this bound
	always_comb begin
		gap_d = gap_q + 32'h1;
		if (shutdown || (redrive_en && !low_power) || rx_detect_start != 2'h0) begin
			gap_d = 32'h0;
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			gap_q <= 32'h0;
		end else begin
			gap_q <= gap_d;
		end
	end
	// level 3 on a strap reads as floating
	function automatic logic [1:0] f3(input logic [1:0] l);
		return (l == 2'h3) ? 2'h1 : l;
	endfunction
	default clocking @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	sequence s_wake;
		$fell(shutdown);
	endsequence
	property p_gap;
		gap_q <= DET_PERIOD_CYC + 32'h8;
	endproperty
	a_gap: assert property (p_gap) else $error("probe gap too long");
	property p_probe;
		rx_detect_start != 2'h0 |-> rx_detect_start == 2'h3 && !shutdown;
	endproperty
	a_probe: assert property (p_probe) else $error("bad probe");
	property p_term;
		redrive_en |-> rx_term_en == 2'h3;
	endproperty
	a_term: assert property (p_term) else $error("termination off");
	property p_gate;
		(far_term_seen != 2'h3) [*5] |-> !redrive_en;
	endproperty
	a_gate: assert property (p_gate) else $error("active without both");
	property p_stay;
		(rx_activity == 2'h3 && far_term_seen == 2'h3 && enable_pin) [*6] |-> !low_power;
	endproperty
	a_stay: assert property (p_stay) else $error("left active");
	property p_off;
		(!enable_pin) [*5] |-> shutdown && !redrive_en;
	endproperty
	a_off: assert property (p_off) else $error("no shutdown");
	property p_lfps;
		lfps_seen[0] [*6] |-> tx_deemph[0] == 2'h0;
	endproperty
	a_lfps: assert property (p_lfps) else $error("deemph in lfps");
	property p_gain;
		$stable(rx_gain_select[1]) [*6] |-> eq_gain[1] == f3(rx_gain_select[1]);
	endproperty
	a_gain: assert property (p_gain) else $error("gain decode");
	property p_wake;
		s_wake |-> !redrive_en && !low_power;
	endproperty
	a_wake: assert property (p_wake) else $error("wake not disconnect");
endmodule
bind rdpm_core rdpm_props #(.DET_PERIOD_CYC(DET_PERIOD_CYC)) i_rdpm_props (.hclk, .hresetn, .enable_pin,
	.rx_gain_select, .far_term_seen, .rx_activity, .lfps_seen, .rx_detect_start, .rx_term_en,
	.redrive_en, .low_power, .shutdown, .eq_gain, .tx_deemph);

// file: rdpm_far_end.sv
`timescale 1ns/100ps
// ****************
// far end model
// ****************
module rdpm_far_end #(
	parameter int LAG = 3
) (
	// clock
	input wire logic hclk,
	// scenario controls
	input wire logic [1:0] present,
	input wire logic traffic,
	input wire logic [1:0] lfps,
	// redriver side
	input wire logic [1:0] rx_detect_start,
	output logic [1:0] far_term_seen,
	output logic [1:0] rx_activity,
	output logic [1:0] lfps_seen
);
	logic [1:0] hit_q = 2'h0;
	int lag_q = 0;
	// answers a probe only after LAG cycles, so a design that skips probing never connects
	always @(posedge hclk) begin
		if (rx_detect_start != 2'h0) begin
			lag_q <= LAG;
		end else if (lag_q > 0) begin
			lag_q <= lag_q - 1;
		end
		hit_q <= (lag_q == 1) ? present : (hit_q & present);
	end
	assign far_term_seen = hit_q & present;
	assign rx_activity = {2{traffic}};
	assign lfps_seen = lfps;
endmodule

// file: redriver_power_mode_control_test.sv
`timescale 1ns/100ps
module redriver_power_mode_control_test;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic hresp;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hrdy;
	logic enable_pin = 1'b0;
	logic [1:0] gsel [2] = '{2'h0, 2'h0};
	logic ssel [2] = '{1'b0, 1'b0};
	logic [1:0] dsel [2] = '{2'h0, 2'h0};
	logic [1:0] term, act, lfs, det, rte;
	logic red, lp, sd;
	logic [1:0] eq [2];
	logic sw [2];
	logic [1:0] de [2];
	logic [1:0] present = 2'h0;
	logic traffic = 1'b0;
	logic [1:0] lfps = 2'h0;
	logic [31:0] rd;
	logic [1:0] e;
	int miscompares = 0;
	int n_compared = 0;
	int cyc = 0;
	int pulses = 0;
	int i;
	always #25 hclk = ~hclk;
	// the lone slave's hreadyout is the bus hready
	rdpm_core #(.IDLE_CYC(32'ha)) i_rdpm_core (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready(hrdy), .hrdata, .hreadyout(hrdy), .hresp, .enable_pin,
		.rx_gain_select(gsel), .tx_swing_select(ssel), .tx_deemph_select(dsel), .far_term_seen(term),
		.rx_activity(act), .lfps_seen(lfs), .rx_detect_start(det), .rx_term_en(rte), .redrive_en(red),
		.low_power(lp), .shutdown(sd), .eq_gain(eq), .tx_swing(sw), .tx_deemph(de));
	rdpm_far_end i_rdpm_far_end (.hclk, .present, .traffic, .lfps, .rx_detect_start(det),
		.far_term_seen(term), .rx_activity(act), .lfps_seen(lfs));
	// ****************
	// bus and checks
	// ****************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// address phase held until hready, then data phase held until hready
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		hsize <= 3'h2;
		@(posedge hclk);
		while (hrdy !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hrdy !== 1'b1) @(posedge hclk);
		rd = hrdata;
		chk(hresp, 1'b0);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] x);
		bus(1'b0, a, 32'h0);
		chk(rd, x);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge hclk);
	endtask
	task automatic print_verdict;
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// probe counting and hang guard
	always @(posedge hclk) begin
		cyc++;
		if (det === 2'h3) pulses++;
		if (cyc == 5000) begin
			miscompares++;
			print_verdict();
		end
	end
	// ****************
	// scenarios
	// ****************
	initial begin
		tick(8);
		hresetn <= 1'b1;
		tick(1);
		rdc(8'h10, 32'h7d0);
		bus(1'b1, 8'h10, 32'h0);
		rdc(8'h10, 32'h1);
		bus(1'b1, 8'h10, 32'h14);
		bus(1'b1, 8'h20, 32'h5a5a5a5a);
		rdc(8'h20, 32'h0);
		chk(sd, 1'b1);
		enable_pin <= 1'b1;
		pulses = 0;
		tick(90);
		chk({pulses > 2, sd, red, rte}, 5'h10);
		present <= 2'h1;
		tick(60);
		chk(red, 1'b0);
		present <= 2'h3;
		traffic <= 1'b1;
		for (i = 0; i < 99 && red !== 1'b1; i++) tick(1);
		chk({red, rte}, 3'h7);
		tick(40);
		rdc(8'h04, 32'hf3);
		traffic <= 1'b0;
		for (i = 0; i < 99 && lp !== 1'b1; i++) tick(1);
		pulses = 0;
		// force low power bit reads back, then is cleared before traffic returns
		bus(1'b1, 8'h00, 32'h1);
		rdc(8'h00, 32'h1);
		bus(1'b1, 8'h00, 32'h0);
		rdc(8'h00, 32'h0);
		tick(52);
		chk({lp, pulses > 1}, 2'h3);
		traffic <= 1'b1;
		tick(8);
		chk(lp, 1'b0);
		// every strap level on both channels, crossed so neither can copy the other
		for (i = 0; i < 4; i++) begin
			gsel[0] <= i[1:0];
			gsel[1] <= 2'h3 - i[1:0];
			ssel[0] <= i[0];
			ssel[1] <= ~i[0];
			dsel[0] <= i[1:0];
			dsel[1] <= 2'h3 - i[1:0];
			tick(8);
			e = (i == 3) ? 2'h1 : i[1:0];
			chk({eq[0], sw[0], de[0]}, {e, i[0], e});
			rdc(8'h08, {e, i[0], e});
			e = (i == 0) ? 2'h1 : 2'h3 - i[1:0];
			chk({eq[1], sw[1], de[1]}, {e, ~i[0], e});
		end
		lfps <= 2'h1;
		tick(8);
		chk(de[0], 2'h0);
		lfps <= 2'h0;
		tick(8);
		chk(de[0], 2'h1);
		enable_pin <= 1'b0;
		present <= 2'h0;
		tick(6);
		chk({sd, red, lp}, 3'h4);
		enable_pin <= 1'b1;
		tick(6);
		chk({sd, red}, 2'h0);
		present <= 2'h3;
		for (i = 0; i < 99 && red !== 1'b1; i++) tick(1);
		chk(red, 1'b1);
		present <= 2'h2;
		tick(6);
		chk(red, 1'b0);
		print_verdict();
	end
endmodule
